//--- csm_defines.svh
// register offsets, field positions, reset values and codes of the channel configuration block
`ifndef CSM_DEFINES_SVH
`define CSM_DEFINES_SVH

`define CSM_ADDR_W            8
`define CSM_DATA_W            8

`define CSM_ADDR_IDENT_LO     8'h00
`define CSM_ADDR_IDENT_HI     8'h01
`define CSM_ADDR_STRAP_STAT   8'h02
`define CSM_ADDR_PLL_ENABLE   8'h03
`define CSM_ADDR_APLL_CTRL    8'h04
`define CSM_ADDR_MCLK_CTRL    8'h05
`define CSM_ADDR_DPLL_MODE    8'h06
`define CSM_ADDR_NCO_B0       8'h07
`define CSM_ADDR_NCO_B3       8'h0A
`define CSM_ADDR_SSC_RATE     8'h0B
`define CSM_ADDR_SSC_RANGE    8'h0C
`define CSM_ADDR_MODE_STAT    8'h0D

`define CSM_BIT_DPLL_EN       0
`define CSM_POS_APLL_SEL      0
`define CSM_BIT_DOUBLER       0
`define CSM_POS_MCLK_FREQ     1
`define CSM_POS_OP_MODE       0
`define CSM_POS_REF_SEL       2

`define CSM_RST_DPLL_EN       1'b0
`define CSM_RST_APLL_SEL      3'h0
`define CSM_RST_DOUBLER       1'b0
`define CSM_RST_MCLK_FREQ     2'h0
`define CSM_RST_OP_MODE       2'h0
`define CSM_RST_REF_SEL       2'h0
`define CSM_RST_NCO           32'h0000_0000
`define CSM_RST_SSC           8'h00

`define CSM_OP_JITTER_ATT     2'h0
`define CSM_OP_NCO            2'h1
`define CSM_OP_SSC            2'h2

`define CSM_IF_SPI            2'h3
`define CSM_I2C_BASE_A        5'h10
`define CSM_I2C_BASE_B        5'h11
`define CSM_AC_EE_PROGRAM     2'h0

`endif

//--- csm_pkg.sv
// types shared by the channel configuration block
package csm_pkg;

	typedef struct packed {
		logic test;
		logic autocfg_strap_hi;
		logic autocfg_strap_lo;
		logic host_if_strap_hi;
		logic host_if_strap_lo;
	} csm_strap_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} csm_reg_req_t;

	typedef struct packed {
		logic        digital_pll_enable;
		logic [2:0]  analog_pll_input_select;
		logic        doubler_enable;
		logic [1:0]  master_clock_freq_field;
		logic [1:0]  op_mode;
		logic [1:0]  dpll_ref_sel;
		logic [31:0] nco_freq;
		logic [7:0]  ssc_rate;
		logic [7:0]  ssc_range;
	} csm_cfg_t;

	typedef struct packed {
		logic        input_block_en;
		logic        dpll_full_en;
		logic        dpll_core_en;
		logic        monitor_en;
		logic        jitter_filter_en;
		logic        apll_only;
		logic        combined;
		logic [1:0]  dpll_ref_sel;
		logic        nco_active;
		logic [31:0] nco_freq;
		logic        ssc_active;
		logic [7:0]  ssc_rate;
		logic [7:0]  ssc_range;
		logic        doubler_enable;
		logic [1:0]  master_clock_freq_field;
		logic        spi_mode;
		logic [6:0]  i2c_addr;
		logic        host_if_active;
		logic        ring_osc_sel;
		logic        test_mode_en;
		logic [1:0]  test_mode_sel;
		logic        eeprom_prog_en;
		logic        eeprom_load;
		logic [1:0]  eeprom_slot;
	} csm_chan_out_t;

	typedef enum logic [1:0] {
		CSM_ST_HELD,
		CSM_ST_LOAD,
		CSM_ST_RUN
	} csm_chan_state_t;

endpackage

//--- csm_strap_latch.sv
// strap capture on the release of one channel reset
`timescale 1ns/100ps
module csm_strap_latch
	import csm_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       channel_reset_n_i,
	input  wire csm_strap_t strap_i,
	output csm_strap_t      strap_o,
	output logic            latch_o
);

	logic       rst_prev;
	logic       next_rst_prev;
	csm_strap_t next_strap;
	logic       next_latch;

	always_comb begin
		next_rst_prev = channel_reset_n_i;
		next_latch    = channel_reset_n_i & ~rst_prev;
		// value held until the next release
		next_strap    = next_latch ? strap_i : strap_o;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rst_prev <= 1'b0;
			strap_o  <= '0;
			latch_o  <= 1'b0;
		end else begin
			rst_prev <= next_rst_prev;
			strap_o  <= next_strap;
			latch_o  <= next_latch;
		end
	end

endmodule

//--- csm_dual_channel.sv
// dual-channel strap capture, mode decode and per-channel register map
`timescale 1ns/100ps
`include "csm_defines.svh"
module csm_dual_channel
	import csm_pkg::*;
#(
	parameter int          NUM_CH   = 2,
	parameter logic [11:0] IDENT    = 12'h05A,   // arbitrary value
	parameter logic [3:0]  REVISION = 4'h1       // arbitrary value
)(
	input  wire logic                        CLK_I,
	input  wire logic                        NRST_I,
	input  wire logic [NUM_CH-1:0]           CHANNEL_RESET_N_I,
	input  wire csm_strap_t [NUM_CH-1:0]     STRAP_I,
	input  wire logic [NUM_CH-1:0]           MCLK_READY_I,
	input  wire csm_reg_req_t [NUM_CH-1:0]   REG_REQ_I,
	output logic [NUM_CH-1:0][7:0]           REG_RDATA_O,
	output logic [NUM_CH-1:0]                REG_RVALID_O,
	output csm_chan_out_t [NUM_CH-1:0]       CHAN_O
);

	////////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	if (NUM_CH < 1 || NUM_CH > 2) begin : g_bad_num_ch
		$error("NUM_CH must be 1 or 2");
	end

	if (`CSM_ADDR_NCO_B3 - `CSM_ADDR_NCO_B0 != 8'h03) begin : g_bad_nco_span
		$error("NCO frequency word needs four byte registers");
	end

	if (`CSM_I2C_BASE_A == `CSM_I2C_BASE_B) begin : g_bad_i2c_base
		$error("channel I2C addresses must differ");
	end

	if ($bits(csm_strap_t) > 8) begin : g_bad_strap_width
		$error("strap status must fit one register");
	end

	////////////////////////////////////////////////////////////////////////////////
	// shared decoding

	function automatic logic is_apll_only(input logic [2:0] sel);
		return ~sel[2];
	endfunction

	function automatic logic is_combined(input logic [2:0] sel, input logic en);
		return (sel[2:1] == 2'b11) && en;
	endfunction

	function automatic logic [7:0] strap_byte(input csm_strap_t s);
		return {3'h0, s};
	endfunction

	function automatic logic [7:0] mode_byte(input csm_cfg_t c);
		logic ao;
		logic cb;
		ao = is_apll_only(c.analog_pll_input_select);
		cb = is_combined(c.analog_pll_input_select, c.digital_pll_enable);
		return {4'h0, c.digital_pll_enable & ~ao, cb, ao, c.digital_pll_enable};
	endfunction

	function automatic logic [1:0] autocfg_code(input csm_strap_t s);
		return {s.autocfg_strap_hi, s.autocfg_strap_lo};
	endfunction

	function automatic logic [1:0] host_if_code(input csm_strap_t s);
		return {s.host_if_strap_hi, s.host_if_strap_lo};
	endfunction

	function automatic logic is_nco_addr(input logic [7:0] addr);
		return (addr >= `CSM_ADDR_NCO_B0) && (addr <= `CSM_ADDR_NCO_B3);
	endfunction

	function automatic logic [6:0] i2c_addr_for(input int chan, input csm_strap_t s);
		// upper bits name the channel, low bits echo the interface straps
		return {(chan == 0) ? `CSM_I2C_BASE_A : `CSM_I2C_BASE_B, host_if_code(s)};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// one independent slice per channel

	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan

		////////////////////////////////////////////////////////////////////////////
		// per-channel state

		csm_strap_t      strap;
		logic            latch_pulse;
		logic            chan_rst;
		csm_chan_state_t state;
		csm_chan_state_t next_state;
		csm_cfg_t        cfg;
		csm_cfg_t        next_cfg;
		csm_chan_out_t   out_q;
		csm_chan_out_t   next_out;
		logic [7:0]      rdata;
		logic [7:0]      next_rdata;
		logic            rvalid;
		logic            next_rvalid;
		logic            host_active;
		logic            eeprom_fire;
		logic [1:0]      nco_idx;

		// either reset holds this channel; NRST_I holds every channel, the channel reset this one alone
		assign chan_rst = ~NRST_I | ~CHANNEL_RESET_N_I[ch];

		csm_strap_latch u_strap (
			.clk_i             (CLK_I),
			.nrst_i            (NRST_I),
			.channel_reset_n_i (CHANNEL_RESET_N_I[ch]),
			.strap_i           (STRAP_I[ch]),
			.strap_o           (strap),
			.latch_o           (latch_pulse)
		);

		////////////////////////////////////////////////////////////////////////////
		// start-up sequence

		always_comb begin
			next_state  = state;
			eeprom_fire = 1'b0;
			case (state)
				CSM_ST_HELD: begin
					if (latch_pulse) begin
						next_state = CSM_ST_LOAD;
					end
				end
				CSM_ST_LOAD: begin
					// loading waits for the latched straps
					eeprom_fire = ~strap.test;
					next_state  = CSM_ST_RUN;
				end
				CSM_ST_RUN: begin
					next_state = CSM_ST_RUN;
				end
				default: begin
					next_state = CSM_ST_HELD;
				end
			endcase
		end

		always_ff @(posedge CLK_I) begin
			if (chan_rst) begin
				state <= CSM_ST_HELD;
			end else begin
				state <= next_state;
			end
		end

		assign host_active = (state != CSM_ST_HELD);

		////////////////////////////////////////////////////////////////////////////
		// register writes, own port only

		assign nco_idx = 2'(REG_REQ_I[ch].addr - `CSM_ADDR_NCO_B0);

		always_comb begin
			next_cfg = cfg;
			if (REG_REQ_I[ch].wr && host_active) begin
				if (REG_REQ_I[ch].addr == `CSM_ADDR_PLL_ENABLE) begin
					next_cfg.digital_pll_enable = REG_REQ_I[ch].wdata[`CSM_BIT_DPLL_EN];
				end else if (REG_REQ_I[ch].addr == `CSM_ADDR_APLL_CTRL) begin
					next_cfg.analog_pll_input_select = REG_REQ_I[ch].wdata[`CSM_POS_APLL_SEL +: 3];
				end else if (REG_REQ_I[ch].addr == `CSM_ADDR_MCLK_CTRL) begin
					next_cfg.doubler_enable          = REG_REQ_I[ch].wdata[`CSM_BIT_DOUBLER];
					next_cfg.master_clock_freq_field = REG_REQ_I[ch].wdata[`CSM_POS_MCLK_FREQ +: 2];
				end else if (REG_REQ_I[ch].addr == `CSM_ADDR_DPLL_MODE) begin
					next_cfg.op_mode      = REG_REQ_I[ch].wdata[`CSM_POS_OP_MODE +: 2];
					next_cfg.dpll_ref_sel = REG_REQ_I[ch].wdata[`CSM_POS_REF_SEL +: 2];
				end else if (is_nco_addr(REG_REQ_I[ch].addr)) begin
					// one byte of the NCO word per address
					next_cfg.nco_freq[8*nco_idx +: 8] = REG_REQ_I[ch].wdata;
				end else if (REG_REQ_I[ch].addr == `CSM_ADDR_SSC_RATE) begin
					next_cfg.ssc_rate = REG_REQ_I[ch].wdata;
				end else if (REG_REQ_I[ch].addr == `CSM_ADDR_SSC_RANGE) begin
					next_cfg.ssc_range = REG_REQ_I[ch].wdata;
				end
				// identification and strap status ignore writes
			end
		end

		always_ff @(posedge CLK_I) begin
			if (chan_rst) begin
				cfg.digital_pll_enable      <= `CSM_RST_DPLL_EN;
				cfg.analog_pll_input_select <= `CSM_RST_APLL_SEL;
				cfg.doubler_enable          <= `CSM_RST_DOUBLER;
				cfg.master_clock_freq_field <= `CSM_RST_MCLK_FREQ;
				cfg.op_mode                 <= `CSM_RST_OP_MODE;
				cfg.dpll_ref_sel            <= `CSM_RST_REF_SEL;
				cfg.nco_freq                <= `CSM_RST_NCO;
				cfg.ssc_rate                <= `CSM_RST_SSC;
				cfg.ssc_range               <= `CSM_RST_SSC;
			end else begin
				cfg <= next_cfg;
			end
		end

		////////////////////////////////////////////////////////////////////////////
		// register reads, map starts at zero

		always_comb begin
			next_rdata  = 8'h00;
			next_rvalid = REG_REQ_I[ch].rd && host_active;
			if (REG_REQ_I[ch].addr == `CSM_ADDR_IDENT_LO) begin
				next_rdata = IDENT[7:0];
			end else if (REG_REQ_I[ch].addr == `CSM_ADDR_IDENT_HI) begin
				next_rdata = {IDENT[11:8], REVISION};
			end else if (REG_REQ_I[ch].addr == `CSM_ADDR_STRAP_STAT) begin
				next_rdata = strap_byte(strap);
			end else if (REG_REQ_I[ch].addr == `CSM_ADDR_PLL_ENABLE) begin
				next_rdata = {7'h00, cfg.digital_pll_enable};
			end else if (REG_REQ_I[ch].addr == `CSM_ADDR_APLL_CTRL) begin
				next_rdata = {5'h00, cfg.analog_pll_input_select};
			end else if (REG_REQ_I[ch].addr == `CSM_ADDR_MCLK_CTRL) begin
				next_rdata = {5'h00, cfg.master_clock_freq_field, cfg.doubler_enable};
			end else if (REG_REQ_I[ch].addr == `CSM_ADDR_DPLL_MODE) begin
				next_rdata = {4'h0, cfg.dpll_ref_sel, cfg.op_mode};
			end else if (is_nco_addr(REG_REQ_I[ch].addr)) begin
				next_rdata = cfg.nco_freq[8*nco_idx +: 8];
			end else if (REG_REQ_I[ch].addr == `CSM_ADDR_SSC_RATE) begin
				next_rdata = cfg.ssc_rate;
			end else if (REG_REQ_I[ch].addr == `CSM_ADDR_SSC_RANGE) begin
				next_rdata = cfg.ssc_range;
			end else if (REG_REQ_I[ch].addr == `CSM_ADDR_MODE_STAT) begin
				next_rdata = mode_byte(cfg);
			end
			// reads of held or idle ports return zero
			if (!next_rvalid) begin
				next_rdata = 8'h00;
			end
		end

		always_ff @(posedge CLK_I) begin
			if (chan_rst) begin
				rdata  <= 8'h00;
				rvalid <= 1'b0;
			end else begin
				rdata  <= next_rdata;
				rvalid <= next_rvalid;
			end
		end

		assign REG_RDATA_O[ch]  = rdata;
		assign REG_RVALID_O[ch] = rvalid;

		////////////////////////////////////////////////////////////////////////////
		// mode decode and strap-driven outputs

		always_comb begin
			logic apll_only;
			logic combined;
			apll_only = is_apll_only(next_cfg.analog_pll_input_select);
			combined  = is_combined(next_cfg.analog_pll_input_select,
				next_cfg.digital_pll_enable);
			next_out                  = '0;
			next_out.apll_only        = apll_only;
			next_out.combined         = combined;
			// analog-only and unknown codes keep monitors off
			if (combined) begin
				if (next_cfg.op_mode == `CSM_OP_NCO) begin
					next_out.dpll_core_en = 1'b1;
					next_out.nco_active   = 1'b1;
				end else if (next_cfg.op_mode == `CSM_OP_SSC) begin
					next_out.dpll_core_en = 1'b1;
					next_out.ssc_active   = 1'b1;
				end else begin
					next_out.input_block_en   = 1'b1;
					next_out.dpll_full_en     = 1'b1;
					next_out.dpll_core_en     = 1'b1;
					next_out.monitor_en       = 1'b1;
					next_out.jitter_filter_en = 1'b1;
				end
			end
			if (!next_cfg.digital_pll_enable) begin
				next_out.input_block_en = 1'b0;
				next_out.dpll_full_en   = 1'b0;
				next_out.dpll_core_en   = 1'b0;
			end

			// settings passed straight through
			next_out.dpll_ref_sel            = next_cfg.dpll_ref_sel;
			next_out.nco_freq                = next_cfg.nco_freq;
			next_out.ssc_rate                = next_cfg.ssc_rate;
			next_out.ssc_range               = next_cfg.ssc_range;
			next_out.doubler_enable          = next_cfg.doubler_enable;
			next_out.master_clock_freq_field = next_cfg.master_clock_freq_field;

			// strap-driven host port and start-up outputs
			next_out.spi_mode                = (host_if_code(strap) == `CSM_IF_SPI);
			next_out.i2c_addr                = next_out.spi_mode ? 7'h00 : i2c_addr_for(ch, strap);
			next_out.host_if_active          = next_state != CSM_ST_HELD;
			next_out.ring_osc_sel            = ~MCLK_READY_I[ch];
			next_out.test_mode_en            = strap.test;
			next_out.test_mode_sel           = strap.test ? autocfg_code(strap) : 2'h0;
			next_out.eeprom_prog_en          = strap.test
				&& (autocfg_code(strap) == `CSM_AC_EE_PROGRAM);
			next_out.eeprom_load             = eeprom_fire;
			next_out.eeprom_slot             = autocfg_code(strap);
		end

		always_ff @(posedge CLK_I) begin
			if (chan_rst) begin
				out_q              <= '0;
				out_q.apll_only    <= 1'b1;
				out_q.ring_osc_sel <= 1'b1;
			end else begin
				out_q <= next_out;
			end
		end

		assign CHAN_O[ch] = out_q;

	end

endmodule

//--- csm_dual_channel_sva.sv
// checker for the dual-channel configuration block
`timescale 1ns/100ps
module csm_dual_channel_sva
	import csm_pkg::*;
#(
	parameter int NUM_CH = 2
)(
	input wire logic                      CLK_I,
	input wire logic                      NRST_I,
	input wire logic [NUM_CH-1:0]         CHANNEL_RESET_N_I,
	input wire csm_strap_t [NUM_CH-1:0]   STRAP_I,
	input wire logic [NUM_CH-1:0]         MCLK_READY_I,
	input wire csm_reg_req_t [NUM_CH-1:0] REG_REQ_I,
	input wire logic [NUM_CH-1:0][7:0]    REG_RDATA_O,
	input wire logic [NUM_CH-1:0]         REG_RVALID_O,
	input wire csm_chan_out_t [NUM_CH-1:0] CHAN_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	////////////////////////////////////////////////////////////////
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		chk_held_quiet: assert property (!CHANNEL_RESET_N_I[c] |=> !REG_RVALID_O[c] && CHAN_O[c].apll_only
			&& !CHAN_O[c].host_if_active) else $error("held channel not quiet");
		chk_apll_only_off: assert property (CHAN_O[c].apll_only |-> !CHAN_O[c].monitor_en
			&& !CHAN_O[c].jitter_filter_en && !CHAN_O[c].combined) else $error("apll-only mode has monitors");
		chk_input_needs_dpll: assert property (CHAN_O[c].input_block_en |-> CHAN_O[c].dpll_core_en
			&& CHAN_O[c].combined) else $error("input block on without digital pll");
		chk_nco_shutdown: assert property (CHAN_O[c].nco_active |-> !CHAN_O[c].input_block_en
			&& !CHAN_O[c].ssc_active && CHAN_O[c].dpll_core_en) else $error("nco mode leaves input block on");
		chk_ssc_shutdown: assert property (CHAN_O[c].ssc_active |-> !CHAN_O[c].input_block_en
			&& !CHAN_O[c].dpll_full_en) else $error("ssc mode leaves input block on");
		chk_read_answer: assert property (REG_REQ_I[c].rd && CHAN_O[c].host_if_active && CHANNEL_RESET_N_I[c]
			|=> REG_RVALID_O[c]) else $error("read not answered");
		chk_rdata_idle: assert property (!REG_RVALID_O[c] |-> REG_RDATA_O[c] == 8'h00)
			else $error("read data not zero");
		chk_answer_cause: assert property (REG_RVALID_O[c] |-> $past(REG_REQ_I[c].rd)
			&& $past(CHAN_O[c].host_if_active)) else $error("answer without request");
		chk_strap_hold: assert property (CHAN_O[c].host_if_active && $past(CHAN_O[c].host_if_active)
			|-> $stable({CHAN_O[c].spi_mode, CHAN_O[c].i2c_addr, CHAN_O[c].test_mode_en,
			CHAN_O[c].test_mode_sel, CHAN_O[c].eeprom_slot})) else $error("latched straps changed");
		chk_i2c_base: assert property (CHAN_O[c].host_if_active && !CHAN_O[c].spi_mode
			|-> CHAN_O[c].i2c_addr[6:2] == 5'(16 + c)) else $error("wrong i2c address");
		chk_autoload: assert property ($rose(CHAN_O[c].host_if_active) && !CHAN_O[c].test_mode_en
			|=> CHAN_O[c].eeprom_load ##1 !CHAN_O[c].eeprom_load) else $error("autoload pulse wrong");
		chk_eeprom_prog: assert property (CHAN_O[c].host_if_active && CHAN_O[c].test_mode_en
			&& CHAN_O[c].test_mode_sel == 2'h0 |-> CHAN_O[c].eeprom_prog_en) else $error("no eeprom program");
		chk_ring_osc: assert property (!MCLK_READY_I[c] |=> CHAN_O[c].ring_osc_sel)
			else $error("ring oscillator not selected");
		cov_read: cover property (REG_RVALID_O[c]);
		cov_combined: cover property (CHAN_O[c].combined && CHAN_O[c].jitter_filter_en);
		cov_nco: cover property (CHAN_O[c].nco_active);
		cov_load: cover property (CHAN_O[c].eeprom_load);
	end
endmodule

//--- csm_host_model.sv
// host processor model driving one channel's register port
`timescale 1ns/100ps
module csm_host_model
	import csm_pkg::*;
(
	input  wire logic       clk_i,
	output csm_reg_req_t    req_o,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i
);
	initial req_o = '{1'b0, 1'b0, 8'hFF, 8'hFF};
	////////////////////////////////////////////////////////////////
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{1'b1, 1'b0, a, d};
		@(posedge clk_i);
		req_o <= '{1'b0, 1'b0, ~a, ~d};
		#1;
	endtask
	task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
		int i;
		ok = 1'b0;
		d = 8'h00;
		@(posedge clk_i);
		req_o <= '{1'b0, 1'b1, a, ~a};
		@(posedge clk_i);
		req_o <= '{1'b0, 1'b0, ~a, a};
		for (i = 0; i < 4 && !ok; i++) begin
			#1;
			if (rvalid_i === 1'b1) begin
				d = rdata_i;
				ok = 1'b1;
			end else begin
				@(posedge clk_i);
			end
		end
	endtask
endmodule

//--- csm_testbench.sv
// testbench for the dual-channel configuration block
`timescale 1ns/100ps
module testbench
	import csm_pkg::*;
;
	localparam logic [11:0] ID_VAL  = 12'h3C7; // arbitrary value
	localparam logic [3:0]  REV_VAL = 4'h2;    // arbitrary value
	logic                CLK_I = 1'b0;
	logic                NRST_I = 1'b0;
	logic [1:0]          ch_rst_n = 2'b00;
	csm_strap_t [1:0]    strap = '0;
	logic [1:0]          mclk_rdy = 2'b11;
	csm_reg_req_t [1:0]  req;
	logic [1:0][7:0]     rdata;
	logic [1:0]          rvalid;
	csm_chan_out_t [1:0] chan;
	int                  mismatches = 0;
	int                  n_tests = 0;
	csm_dual_channel #(.NUM_CH(2), .IDENT(ID_VAL), .REVISION(REV_VAL)) DUT (.CLK_I(CLK_I), .NRST_I(NRST_I),
		.CHANNEL_RESET_N_I(ch_rst_n), .STRAP_I(strap), .MCLK_READY_I(mclk_rdy), .REG_REQ_I(req),
		.REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .CHAN_O(chan));
	csm_host_model host0 (.clk_i(CLK_I), .req_o(req[0]), .rdata_i(rdata[0]), .rvalid_i(rvalid[0]));
	csm_host_model host1 (.clk_i(CLK_I), .req_o(req[1]), .rdata_i(rdata[1]), .rvalid_i(rvalid[1]));
	initial begin
		forever #50 CLK_I = ~CLK_I;
	end
	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic wr(input int c, input logic [7:0] a, input logic [7:0] d);
		if (c == 0) host0.write(a, d);
		else host1.write(a, d);
	endtask
	task automatic rd_chk(input int c, input logic [7:0] a, input logic [7:0] exp, input string msg);
		logic [7:0] d;
		logic ok;
		if (c == 0) host0.read(a, d, ok);
		else host1.read(a, d, ok);
		if (!ok) begin
			mismatches++;
			$display("CHECK FAILED t=%0t no read answer", $time);
			end_sim();
		end else begin
			chk(d, exp, msg);
		end
	endtask
	task automatic release_ch(input int c, input csm_strap_t s);
		logic seen;
		int i;
		seen = 1'b0;
		@(posedge CLK_I);
		ch_rst_n[c] <= 1'b0;
		strap[c] <= s;
		@(posedge CLK_I);
		ch_rst_n[c] <= 1'b1;
		for (i = 0; i < 6; i++) begin
			@(posedge CLK_I);
			#1;
			if (chan[c].eeprom_load === 1'b1) seen = 1'b1;
		end
		chk(seen, !s.test, "autoload");
		chk(chan[c].eeprom_slot, {s.autocfg_strap_hi, s.autocfg_strap_lo}, "slot");
		chk(chan[c].host_if_active, 1'b1, "host active");
		chk(chan[c].spi_mode, s.host_if_strap_hi & s.host_if_strap_lo, "spi mode");
		if (!(s.host_if_strap_hi & s.host_if_strap_lo))
			chk(chan[c].i2c_addr, {5'(16 + c), s.host_if_strap_hi, s.host_if_strap_lo}, "i2c addr");
		chk(chan[c].test_mode_en, s.test, "test mode");
		chk(chan[c].test_mode_sel, s.test ? {s.autocfg_strap_hi, s.autocfg_strap_lo} : 2'b00, "test sel");
		chk(chan[c].eeprom_prog_en, s.test & !s.autocfg_strap_hi & !s.autocfg_strap_lo, "ee prog");
		rd_chk(c, 8'h02, {3'b000, s}, "strap status");
		@(posedge CLK_I);
		strap[c] <= ~s;
		wr(c, 8'h02, 8'hFF);
		rd_chk(c, 8'h02, {3'b000, s}, "strap status held");
	endtask
	task automatic t_ident();
		wr(0, 8'h00, 8'h55);
		rd_chk(0, 8'h00, ID_VAL[7:0], "ident lo");
		rd_chk(1, 8'h01, {ID_VAL[11:8], REV_VAL}, "ident hi");
		rd_chk(0, 8'h40, 8'h00, "unmapped");
	endtask
	task automatic t_modes();
		logic [7:0] tbl [8] = '{8'h00, 8'h98, 8'hB9, 8'hBA, 8'h8C, 8'h18, 8'h9B, 8'h94};
		logic en, ao, cb, ib;
		logic [2:0] sel;
		logic [1:0] op;
		int i;
		for (i = 0; i < 8; i++) begin
			{en, sel, op} = {tbl[i][7], tbl[i][4:2], tbl[i][1:0]};
			wr(0, 8'h03, {7'h00, en});
			wr(0, 8'h04, {5'h00, sel});
			wr(0, 8'h06, {6'h00, op});
			ao = !sel[2];
			cb = sel[2] & sel[1] & en;
			ib = cb & (op == 2'h0 || op == 2'h3);
			chk({chan[0].apll_only, chan[0].combined, chan[0].input_block_en, chan[0].jitter_filter_en,
				chan[0].monitor_en, chan[0].nco_active, chan[0].ssc_active},
				{ao, cb, ib, ib, ib, cb & (op == 2'h1), cb & (op == 2'h2)}, "mode");
			rd_chk(0, 8'h0D, {4'h0, sel[2] & en, cb, ao, en}, "mode status");
		end
		wr(0, 8'h07, 8'h11);
		wr(0, 8'h08, 8'h22);
		wr(0, 8'h09, 8'h33);
		wr(0, 8'h0A, 8'h44);
		chk(chan[0].nco_freq, 32'h4433_2211, "nco freq");
		wr(0, 8'h0B, 8'h5A);
		wr(0, 8'h0C, 8'hA5);
		chk({chan[0].ssc_rate, chan[0].ssc_range}, 16'h5AA5, "ssc");
		wr(0, 8'h05, 8'h05);
		chk({chan[0].doubler_enable, chan[0].master_clock_freq_field}, 3'h6, "doubler");
	endtask
	task automatic t_isolation();
		wr(0, 8'h03, 8'h01);
		wr(0, 8'h04, 8'h06);
		wr(0, 8'h06, 8'h02);
		rd_chk(1, 8'h07, 8'h00, "other channel nco");
		rd_chk(1, 8'h03, 8'h00, "other channel enable");
		wr(1, 8'h03, 8'h01);
		wr(1, 8'h04, 8'h06);
		wr(1, 8'h06, 8'h00);
		chk({chan[1].combined, chan[1].jitter_filter_en, chan[0].ssc_active}, 3'b111, "independent");
	endtask
	task automatic t_ring_osc();
		@(posedge CLK_I);
		mclk_rdy <= 2'b10;
		repeat (2) @(posedge CLK_I);
		#1;
		chk({chan[1].ring_osc_sel, chan[0].ring_osc_sel}, 2'b01, "ring osc");
		@(posedge CLK_I);
		mclk_rdy <= 2'b11;
	endtask
	initial begin
		repeat (5) @(posedge CLK_I);
		NRST_I <= 1'b1;
		release_ch(1, 5'b0_1111);
		release_ch(0, 5'b0_1001);
		t_ident();
		t_modes();
		t_isolation();
		t_ring_osc();
		release_ch(0, 5'b1_0010);
		release_ch(0, 5'b0_0110);
		end_sim();
	end
endmodule
bind csm_dual_channel csm_dual_channel_sva #(.NUM_CH(NUM_CH)) u_sva (.CLK_I(CLK_I), .NRST_I(NRST_I),
	.CHANNEL_RESET_N_I(CHANNEL_RESET_N_I), .STRAP_I(STRAP_I), .MCLK_READY_I(MCLK_READY_I), .REG_REQ_I(REG_REQ_I),
	.REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O), .CHAN_O(CHAN_O));
